/* verilog/crc_calendar.sv */
// calendar counter: sub-second, bcd time and date, hold, interval and divider
`timescale 1ns/1ns
// Behaviour
// - hold freezes calendar, sub-second keeps counting
// - hold status rises within one tick
// - overflow during hold applied after release
// - seconds write clears sub-second, drops deferral
// - flags clear on zero, keep on one
// - periodic and alarm share one interrupt
// - interval interrupt enable and period select
// - divider pin enable and frequency select
// - divider pin stops low within two ticks
// - sub-second counts 0000 to 7FFF
// - calendar writes buffered, applied within two ticks
// - out-of-range values heal within one period
// - seconds and minutes count 00 to 59
// - hour coding for 24 and 12 hour
// - hour resets 12H, 00H in 24-hour
// - day limit follows month and leap year
// - weekday 0 to 6 with day
// - month 1 to 12 on day wrap
// - years divisible by four are leap
// - hold status flag readable by software
module crc_calendar
    import crc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         sub_tick,
    input  wire crc_sfr_req_t sfr_req,
    input  wire logic         alarm_match,
    input  wire logic [7:0]   year_bcd,
    output logic      [15:0]  sfr_rdata,
    output logic              shared_calendar_irq,
    output logic              interval_irq,
    output logic              divider_out_pin,
    output logic              divider_out_oe,
    output logic              clk32k_out_enable
);
    logic [7:0]      rtcc0_r, rtcc0_nxt;
    logic            hold_r, hold_nxt, hstat_r, hstat_nxt;
    logic            pflag_r, pflag_nxt, aflag_r, aflag_nxt;
    logic [7:0]      idc_r, idc_nxt;
    logic [15:0]     subsec_r, subsec_nxt;
    logic            pend_r, pend_nxt;
    logic [7:0]      sec_r, sec_nxt, min_r, min_nxt, hour_r, hour_nxt;
    logic [7:0]      week_r, week_nxt, day_r, day_nxt, mon_r, mon_nxt;
    crc_wsel_t       wb_sel_r, wb_sel_nxt;
    logic [7:0]      wb_dat_r, wb_dat_nxt;
    logic            hour_fresh_r, hour_fresh_nxt;
    logic [IVL_W-1:0] ivl_r, ivl_nxt;
    logic            ivl_irq_nxt, cal_irq_nxt;
    logic            div_nxt, div_oe_nxt;
    logic [15:0]     rdata_nxt;

    logic [7:0] sec_s, min_s, h24_s, week_s, day_s, mon_s, day_last, h12_s;
    logic       sec_w, min_w, h24_w, week_w, day_w, mon_w, h12_w;
    logic       wr, sub_ovf, sub_half, leap, step_sec, step_min, step_hour, step_day;
    logic       pevent;
    crc_ct_t    ct;

    crc_bcd_step u_sec (.cur(sec_r), .last(BCD_59), .first(R8_ZERO), .nxt(sec_s), .wrap(sec_w));
    crc_bcd_step u_min (.cur(min_r), .last(BCD_59), .first(R8_ZERO), .nxt(min_s), .wrap(min_w));
    crc_bcd_step u_h24 (.cur(hour_r), .last(BCD_23), .first(R8_ZERO), .nxt(h24_s), .wrap(h24_w));
    crc_bcd_step u_wk  (.cur(week_r), .last(BCD_06), .first(R8_ZERO), .nxt(week_s), .wrap(week_w));
    crc_bcd_step u_day (.cur(day_r), .last(day_last), .first(BCD_01), .nxt(day_s), .wrap(day_w));
    crc_bcd_step u_mon (.cur(mon_r), .last(BCD_12), .first(BCD_01), .nxt(mon_s), .wrap(mon_w));

    // 12-hour coding: 12, 01..11, 32, 21..31, back to 12 with a day carry
    always_comb begin
        h12_w = 1'b0;
        if (hour_r == BCD_11) begin
            h12_s = BCD_32;
        end else if (hour_r == BCD_32) begin
            h12_s = BCD_21;
        end else if (hour_r == BCD_12) begin
            h12_s = BCD_01;
        end else if (hour_r == BCD_31) begin
            h12_s = BCD_12;
            h12_w = 1'b1;
        end else if ((hour_r < BCD_11) || ((hour_r > BCD_21) && (hour_r < BCD_31))
                     || (hour_r == BCD_21)) begin
            h12_s = (hour_r[3:0] >= 4'h9) ? {hour_r[7:4] + 4'h1, 4'h0} : hour_r + 8'h01;
        end else begin
            h12_s = BCD_12;
        end
    end

    // leap when the year is a multiple of four, in bcd
    always_comb begin
        leap = year_bcd[4] ? ((year_bcd[3:0] == 4'h2) || (year_bcd[3:0] == 4'h6))
                           : ((year_bcd[3:0] == 4'h0) || (year_bcd[3:0] == 4'h4)
                              || (year_bcd[3:0] == 4'h8));
        if (mon_r == MON_FEB) begin
            day_last = leap ? BCD_29 : BCD_28;
        end else if ((mon_r == MON_APR) || (mon_r == MON_JUN) || (mon_r == MON_SEP)
                     || (mon_r == MON_NOV)) begin
            day_last = BCD_30;
        end else begin
            day_last = BCD_31;
        end
    end

    always_comb begin
        wr        = sfr_req.wr;
        sub_ovf   = sub_tick && (subsec_r >= SUB_MAX);
        sub_half  = sub_tick && (subsec_r == SUB_HALF);
        // the calendar moves only while hold is not in effect
        step_sec  = sub_tick && !hstat_r && (sub_ovf || pend_r);
        step_min  = step_sec && sec_w;
        step_hour = step_min && min_w;
        step_day  = step_hour && (rtcc0_r[B0_FMT24] ? h24_w : h12_w);
        ct        = crc_ct_t'(rtcc0_r[2:0]);
        case (ct)
            CT_OFF:   pevent = 1'b0;
            CT_HALF:  pevent = step_sec || (sub_half && !hstat_r);
            CT_SEC:   pevent = step_sec;
            CT_MIN:   pevent = step_min;
            CT_HOUR:  pevent = step_hour;
            CT_DAY:   pevent = step_day;
            default:  pevent = step_day && day_w;
        endcase
    end

    always_comb begin
        rtcc0_nxt = rtcc0_r;
        hold_nxt  = hold_r;
        idc_nxt = idc_r;
        hour_fresh_nxt = hour_fresh_r;
        pflag_nxt = pflag_r;
        aflag_nxt = aflag_r;
        wb_sel_nxt = wb_sel_r;
        wb_dat_nxt = wb_dat_r;
        sec_nxt = sec_r;
        min_nxt = min_r;
        hour_nxt = hour_r;
        week_nxt = week_r;
        day_nxt = day_r;
        mon_nxt = mon_r;
        subsec_nxt = subsec_r;
        pend_nxt = pend_r;
        hstat_nxt = hstat_r;

        if (sub_tick) begin
            subsec_nxt = sub_ovf ? SUB_RST : subsec_r + 16'h0001;
            hstat_nxt  = hold_r;
            if (hstat_r && sub_ovf) begin
                pend_nxt = 1'b1;
            end else if (step_sec) begin
                pend_nxt = 1'b0;
            end
            if (step_sec)  sec_nxt  = sec_s;
            if (step_min)  min_nxt  = min_s;
            if (step_hour) hour_nxt = rtcc0_r[B0_FMT24] ? h24_s : h12_s;
            if (step_day) begin
                day_nxt  = day_s;
                week_nxt = week_s;
            end
            if (step_day && day_w) mon_nxt = mon_s;
            // buffered write lands on the tick after it was taken
            case (wb_sel_r)
                WB_SEC:   sec_nxt  = wb_dat_r;
                WB_MIN:   min_nxt  = wb_dat_r;
                WB_HOUR:  hour_nxt = wb_dat_r;
                WB_WEEK:  week_nxt = wb_dat_r;
                WB_DAY:   day_nxt  = wb_dat_r;
                WB_MONTH: mon_nxt  = wb_dat_r;
                default:  ;
            endcase
            wb_sel_nxt = WB_NONE;
        end

        if (pevent) pflag_nxt = 1'b1;
        if (alarm_match) aflag_nxt = 1'b1;

        if (wr) begin
            case (sfr_req.addr)
                ADDR_RTCC0: begin
                    rtcc0_nxt = sfr_req.wdata[7:0];
                    if (sfr_req.wdata[B0_FMT24] && hour_fresh_r) begin
                        hour_nxt = R8_ZERO;
                    end
                end
                ADDR_AHC: begin
                    hold_nxt = sfr_req.wdata[B1_HOLD];
                    // set beats clear when an event lands on the write
                    if (!sfr_req.wdata[B1_PFLAG] && !pevent) pflag_nxt = 1'b0;
                    if (!sfr_req.wdata[B1_AFLAG] && !alarm_match) aflag_nxt = 1'b0;
                end
                ADDR_IDC: idc_nxt = sfr_req.wdata[7:0] & 8'hE7;
                ADDR_SUBSEC: subsec_nxt = sfr_req.wdata;
                ADDR_SEC: begin
                    wb_sel_nxt = WB_SEC;
                    subsec_nxt = SUB_RST;
                    pend_nxt   = 1'b0;
                end
                ADDR_MIN:   wb_sel_nxt = WB_MIN;
                ADDR_HOUR: begin
                    wb_sel_nxt = WB_HOUR;
                    hour_fresh_nxt = 1'b0;
                end
                ADDR_WEEK:  wb_sel_nxt = WB_WEEK;
                ADDR_DAY:   wb_sel_nxt = WB_DAY;
                ADDR_MONTH: wb_sel_nxt = WB_MONTH;
                default:    ;
            endcase
            wb_dat_nxt = sfr_req.wdata[7:0];
        end
        if (step_hour) hour_fresh_nxt = 1'b0;
    end

    // interval timer runs only while enabled, so disabling it resets the phase
    always_comb begin
        ivl_nxt     = ivl_r;
        ivl_irq_nxt = 1'b0;
        if (!idc_r[B2_IEN]) begin
            ivl_nxt = '0;
        end else if (sub_tick) begin
            ivl_nxt = ivl_r + {{(IVL_W-1){1'b0}}, 1'b1};
            if (idc_r[2]) begin
                ivl_irq_nxt = idc_r[1] ? (&ivl_r[IVL_W-1:0])
                                       : (idc_r[0] ? (&ivl_r[IVL_BASE+4:0])
                                                   : (&ivl_r[IVL_BASE+3:0]));
            end else begin
                case (idc_r[1:0])
                    2'h0:    ivl_irq_nxt = &ivl_r[IVL_BASE-1:0];
                    2'h1:    ivl_irq_nxt = &ivl_r[IVL_BASE:0];
                    2'h2:    ivl_irq_nxt = &ivl_r[IVL_BASE+1:0];
                    default: ivl_irq_nxt = &ivl_r[IVL_BASE+2:0];
                endcase
            end
        end
        cal_irq_nxt = pevent || alarm_match;
        // the divider taps the free-running sub-second counter
        div_oe_nxt  = idc_r[B2_DIVOE];
        div_nxt     = idc_r[B2_DIVOE] && (idc_r[B2_DIVSEL] ? subsec_r[B_DIV_FAST]
                                                           : subsec_r[B_DIV_SLOW]);
        case (sfr_req.addr)
            ADDR_RTCC0:  rdata_nxt = {8'h00, rtcc0_r};
            ADDR_AHC:    rdata_nxt = {8'h00, 3'h0, aflag_r, pflag_r, 1'b0, hstat_r, hold_r};
            ADDR_IDC:    rdata_nxt = {8'h00, idc_r};
            ADDR_SUBSEC: rdata_nxt = subsec_r;
            ADDR_SEC:    rdata_nxt = {8'h00, sec_r};
            ADDR_MIN:    rdata_nxt = {8'h00, min_r};
            ADDR_HOUR:   rdata_nxt = {8'h00, hour_r};
            ADDR_WEEK:   rdata_nxt = {8'h00, week_r};
            ADDR_DAY:    rdata_nxt = {8'h00, day_r};
            ADDR_MONTH:  rdata_nxt = {8'h00, mon_r};
            default:     rdata_nxt = 16'h0000;
        endcase
        if (!sfr_req.rd) rdata_nxt = sfr_rdata;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rtcc0_r <= 8'h00;
            hold_r <= 1'b0;
            hstat_r <= 1'b0;
            pflag_r <= 1'b0;
            aflag_r <= 1'b0;
            idc_r <= 8'h00;
            subsec_r <= SUB_RST;
            pend_r <= 1'b0;
            sec_r <= R8_ZERO;
            min_r <= R8_ZERO;
            hour_r <= HOUR_RST;
            week_r <= R8_ZERO;
            day_r <= DAY_RST;
            mon_r <= MON_RST;
            wb_sel_r <= WB_NONE;
            wb_dat_r <= R8_ZERO;
            hour_fresh_r <= 1'b1;
            ivl_r <= '0;
            interval_irq <= 1'b0;
            shared_calendar_irq <= 1'b0;
            divider_out_pin <= 1'b0;
            divider_out_oe <= 1'b0;
            clk32k_out_enable <= 1'b0;
            sfr_rdata <= 16'h0000;
        end else begin
            rtcc0_r <= rtcc0_nxt;
            hold_r <= hold_nxt;
            hstat_r <= hstat_nxt;
            pflag_r <= pflag_nxt;
            aflag_r <= aflag_nxt;
            idc_r <= idc_nxt;
            subsec_r <= subsec_nxt;
            pend_r <= pend_nxt;
            sec_r <= sec_nxt;
            min_r <= min_nxt;
            hour_r <= hour_nxt;
            week_r <= week_nxt;
            day_r <= day_nxt;
            mon_r <= mon_nxt;
            wb_sel_r <= wb_sel_nxt;
            wb_dat_r <= wb_dat_nxt;
            hour_fresh_r <= hour_fresh_nxt;
            ivl_r <= ivl_nxt;
            interval_irq <= ivl_irq_nxt;
            shared_calendar_irq <= cal_irq_nxt;
            divider_out_pin <= div_nxt;
            divider_out_oe <= div_oe_nxt;
            clk32k_out_enable <= rtcc0_nxt[B0_CK32OE];
            sfr_rdata <= rdata_nxt;
        end
    end

    property p_freeze;
        @(posedge clk) disable iff (sys_rst)
        (hstat_r && wb_sel_r == WB_NONE && !wr) |=> $stable(sec_r) && $stable(min_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("calendar moved during hold");

    property p_subsec;
        @(posedge clk) disable iff (sys_rst)
        (sub_tick && subsec_r < SUB_MAX && !wr) |=> subsec_r == $past(subsec_r) + 16'h0001;
    endproperty
    a_subsec: assert property (p_subsec) else $error("sub-second did not count");

    property p_hstat;
        @(posedge clk) disable iff (sys_rst)
        (hold_r && sub_tick && !wr) |=> hstat_r;
    endproperty
    a_hstat: assert property (p_hstat) else $error("hold status late");

    property p_keep_flag;
        @(posedge clk) disable iff (sys_rst)
        (wr && sfr_req.addr == ADDR_AHC && sfr_req.wdata[B1_PFLAG] && pflag_r) |=> pflag_r;
    endproperty
    a_keep_flag: assert property (p_keep_flag) else $error("flag lost on write of one");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        pevent |=> shared_calendar_irq && pflag_r;
    endproperty
    a_irq: assert property (p_irq) else $error("periodic event missing");

    property p_ivl_off;
        @(posedge clk) disable iff (sys_rst)
        !idc_r[B2_IEN] |=> !interval_irq;
    endproperty
    a_ivl_off: assert property (p_ivl_off) else $error("interval irq while disabled");

    property p_div_low;
        @(posedge clk) disable iff (sys_rst)
        !idc_r[B2_DIVOE] |=> !divider_out_pin && !divider_out_oe;
    endproperty
    a_div_low: assert property (p_div_low) else $error("divider pin not low");

    property p_deferred;
        @(posedge clk) disable iff (sys_rst)
        (pend_r && !hstat_r && sub_tick && wb_sel_r == WB_NONE && !wr) |=> sec_r != $past(sec_r);
    endproperty
    a_deferred: assert property (p_deferred) else $error("deferred second lost");

    c_hold: cover property (@(posedge clk) disable iff (sys_rst) hstat_r && sub_ovf);
    c_day:  cover property (@(posedge clk) disable iff (sys_rst) step_day && day_w);
    c_ivl:  cover property (@(posedge clk) disable iff (sys_rst) interval_irq);
endmodule

/* verilog/crc_pkg.sv */
// shared constants and types of the calendar counter
package crc_pkg;
    localparam logic [15:0] ADDR_RTCC0  = 16'hFF9D;
    localparam logic [15:0] ADDR_AHC    = 16'hFF9E;
    localparam logic [15:0] ADDR_IDC    = 16'hFF6F;
    localparam logic [15:0] ADDR_SUBSEC = 16'hFFC0;
    localparam logic [15:0] ADDR_SEC    = 16'hFFC2;
    localparam logic [15:0] ADDR_MIN    = 16'hFFB3;
    localparam logic [15:0] ADDR_HOUR   = 16'hFFC4;
    localparam logic [15:0] ADDR_WEEK   = 16'hFFB5;
    localparam logic [15:0] ADDR_DAY    = 16'hFFB6;
    localparam logic [15:0] ADDR_MONTH  = 16'hFFB7;

    // field positions
    localparam int B0_FMT24  = 3;
    localparam int B0_CK32OE = 4;
    localparam int B1_HOLD   = 0;
    localparam int B1_HSTAT  = 1;
    localparam int B1_PFLAG  = 3;
    localparam int B1_AFLAG  = 4;
    localparam int B2_IEN    = 7;
    localparam int B2_DIVOE  = 6;
    localparam int B2_DIVSEL = 5;
    localparam int B_DIV_SLOW = 5;
    localparam int B_DIV_FAST = 0;

    localparam logic [15:0] SUB_MAX  = 16'h7FFF;
    localparam logic [15:0] SUB_HALF = 16'h3FFF;
    localparam logic [15:0] SUB_RST  = 16'h0000;
    localparam logic [7:0]  R8_ZERO  = 8'h00;
    localparam logic [7:0]  BCD_59   = 8'h59;
    localparam logic [7:0]  BCD_23   = 8'h23;
    localparam logic [7:0]  BCD_12   = 8'h12;
    localparam logic [7:0]  BCD_11   = 8'h11;
    localparam logic [7:0]  BCD_21   = 8'h21;
    localparam logic [7:0]  BCD_31   = 8'h31;
    localparam logic [7:0]  BCD_32   = 8'h32;
    localparam logic [7:0]  BCD_30   = 8'h30;
    localparam logic [7:0]  BCD_29   = 8'h29;
    localparam logic [7:0]  BCD_28   = 8'h28;
    localparam logic [7:0]  BCD_06   = 8'h06;
    localparam logic [7:0]  BCD_01   = 8'h01;
    localparam logic [7:0]  DAY_RST  = 8'h01;
    localparam logic [7:0]  MON_RST  = 8'h01;
    localparam logic [7:0]  HOUR_RST = 8'h12;
    localparam logic [7:0]  MON_FEB  = 8'h02;
    localparam logic [7:0]  MON_APR  = 8'h04;
    localparam logic [7:0]  MON_JUN  = 8'h06;
    localparam logic [7:0]  MON_SEP  = 8'h09;
    localparam logic [7:0]  MON_NOV  = 8'h11;
    localparam int          IVL_BASE = 6;
    localparam int          IVL_W    = 12;

    typedef enum logic [2:0] {
        CT_OFF, CT_HALF, CT_SEC, CT_MIN, CT_HOUR, CT_DAY, CT_MON_A, CT_MON_B
    } crc_ct_t;

    typedef enum logic [2:0] {
        WB_NONE, WB_SEC, WB_MIN, WB_HOUR, WB_WEEK, WB_DAY, WB_MONTH
    } crc_wsel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } crc_sfr_req_t;
endpackage

/* verilog/crc_bcd_step.sv */
// one step of a bcd counter that wraps from its last value back to its first
`timescale 1ns/1ns
module crc_bcd_step
    import crc_pkg::*;
(
    input  wire logic [7:0] cur,
    input  wire logic [7:0] last,
    input  wire logic [7:0] first,
    output logic      [7:0] nxt,
    output logic            wrap
);
    // anything at or above the last value wraps, so a bad load heals in one period
    always_comb begin
        wrap = (cur >= last);
        if (wrap) begin
            nxt = first;
        end else if (cur[3:0] >= 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = cur + 8'h01;
        end
    end
endmodule

/* testbench/tb_top.sv */
// self-checking bench of the calendar counter, driven through its register port
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top
    import crc_pkg::*;
;
    logic         clk;
    logic         sys_rst;
    logic         sub_tick;
    crc_sfr_req_t sfr_req;
    logic         alarm_match;
    logic [7:0]   year_bcd;
    logic [15:0]  sfr_rdata;
    logic         shared_calendar_irq;
    logic         interval_irq;
    logic         divider_out_pin;
    logic         divider_out_oe;
    logic         clk32k_out_enable;
    int           mismatches;
    int           checks;
    int           tcnt;
    int           sirq;
    int           ivc;
    int           rises;
    int           t0;
    int           t1;
    int           s0;
    logic [15:0]  v;
    logic [15:0]  ra [8] = '{ADDR_IDC, ADDR_MIN, ADDR_WEEK, ADDR_DAY, ADDR_AHC, ADDR_SEC,
                             ADDR_HOUR, ADDR_MONTH};
    logic [15:0]  rv [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
                             16'h0012, 16'h0001};

    crc_calendar i_crc_calendar (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .sub_tick            (sub_tick),
        .sfr_req             (sfr_req),
        .alarm_match         (alarm_match),
        .year_bcd            (year_bcd),
        .sfr_rdata           (sfr_rdata),
        .shared_calendar_irq (shared_calendar_irq),
        .interval_irq        (interval_irq),
        .divider_out_pin     (divider_out_pin),
        .divider_out_oe      (divider_out_oe),
        .clk32k_out_enable   (clk32k_out_enable)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // subsystem tick every second cycle keeps the long interval periods affordable
    always @(negedge clk) sub_tick <= ~sub_tick & ~sys_rst;

    always @(posedge clk) begin
        if (sub_tick === 1'b1) tcnt++;
        if (shared_calendar_irq === 1'b1) sirq++;
        if (interval_irq === 1'b1) ivc++;
    end

    always @(posedge divider_out_pin) rises++;

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic ticks(input int n);
        int s;
        s = tcnt;
        while (tcnt < s + n) @(negedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_req.wr = 1'b1;
        @(negedge clk);
        sfr_req.wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk);
        sfr_req.addr = a;
        sfr_req.rd = 1'b1;
        @(negedge clk);
        sfr_req.rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic chkrd(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask

    // the write buffer holds one value, so each calendar write waits for its landing
    task automatic wc(input logic [15:0] a, input logic [7:0] d);
        wr(a, {8'h00, d});
        ticks(2);
    endtask

    // flag bits written as one so pending flags survive the hold toggling
    task automatic hold_on();
        wr(ADDR_AHC, 16'h0019);
        ticks(1);
        rd(ADDR_AHC, v);
        `CHK(v[1], 1'b1)
    endtask

    task automatic hold_off();
        wr(ADDR_AHC, 16'h0018);
        ticks(2);
    endtask

    task automatic roll(input logic [7:0] fmt, input logic [7:0] h, input logic [7:0] d,
                        input logic [7:0] m, input logic [7:0] y, input logic [7:0] eh,
                        input logic [7:0] ed, input logic [7:0] em);
        hold_on();
        wr(ADDR_RTCC0, {8'h00, fmt});
        year_bcd = y;
        wc(ADDR_SEC, 8'h59);
        wc(ADDR_MIN, 8'h59);
        wc(ADDR_HOUR, h);
        wc(ADDR_WEEK, 8'h06);
        wc(ADDR_DAY, d);
        wc(ADDR_MONTH, m);
        chkrd(ADDR_HOUR, {8'h00, h});
        wr(ADDR_SUBSEC, 16'h7FFC);
        ticks(2);
        hold_off();
        ticks(8);
        hold_on();
        chkrd(ADDR_SEC, 16'h0000);
        chkrd(ADDR_MIN, 16'h0000);
        chkrd(ADDR_HOUR, {8'h00, eh});
        chkrd(ADDR_DAY, {8'h00, ed});
        chkrd(ADDR_MONTH, {8'h00, em});
        chkrd(ADDR_WEEK, (ed != d) ? 16'h0000 : 16'h0006);
    endtask

    task automatic wait_iv(output int t);
        int n;
        n = 0;
        t = -1;
        while (n < 20000 && t < 0) begin
            @(negedge clk);
            n++;
            if (interval_irq === 1'b1) t = tcnt;
        end
    endtask

    initial begin
        #800000;
        mismatches++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        sub_tick = 1'b0;
        sfr_req = '0;
        alarm_match = 1'b0;
        year_bcd = 8'h01;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        `CHK(divider_out_oe, 1'b0)
        foreach (ra[i]) chkrd(ra[i], rv[i]);
        // the sub-second counter runs from release, so only its range is known
        rd(ADDR_SUBSEC, v);
        `CHK(v < 16'h0020, 1'b1)
        chkrd(16'hFF00, 16'h0000);
        wr(ADDR_RTCC0, 16'h0008);
        ticks(2);
        chkrd(ADDR_HOUR, 16'h0000);
        // overflow while held is deferred, a seconds write drops it
        hold_on();
        wc(ADDR_SEC, 8'h20);
        wr(ADDR_SUBSEC, 16'h7FFC);
        ticks(8);
        chkrd(ADDR_SEC, 16'h0020);
        rd(ADDR_SUBSEC, v);
        `CHK(v < 16'h0010, 1'b1)
        hold_off();
        ticks(4);
        hold_on();
        chkrd(ADDR_SEC, 16'h0021);
        wr(ADDR_SUBSEC, 16'h7FFC);
        ticks(8);
        wc(ADDR_SEC, 8'h40);
        hold_off();
        ticks(4);
        hold_on();
        chkrd(ADDR_SEC, 16'h0040);
        roll(8'h02, 8'h31, 8'h28, 8'h02, 8'h01, 8'h12, 8'h01, 8'h03);
        roll(8'h02, 8'h31, 8'h28, 8'h02, 8'h04, 8'h12, 8'h29, 8'h02);
        roll(8'h02, 8'h11, 8'h30, 8'h04, 8'h01, 8'h32, 8'h30, 8'h04);
        roll(8'h0A, 8'h23, 8'h30, 8'h04, 8'h01, 8'h00, 8'h01, 8'h05);
        roll(8'h0A, 8'h23, 8'h31, 8'h12, 8'h01, 8'h00, 8'h01, 8'h01);
        hold_off();
        rd(ADDR_AHC, v);
        `CHK(v[3], 1'b1)
        wr(ADDR_RTCC0, 16'h0000);
        s0 = sirq;
        @(negedge clk);
        alarm_match = 1'b1;
        @(negedge clk);
        alarm_match = 1'b0;
        ticks(2);
        `CHK(sirq, s0 + 1)
        wr(ADDR_AHC, 16'h0010);
        rd(ADDR_AHC, v);
        `CHK(v[4:3], 2'b10)
        wr(ADDR_AHC, 16'h0000);
        rd(ADDR_AHC, v);
        `CHK(v[4:3], 2'b00)
        s0 = ivc;
        ticks(200);
        `CHK(ivc, s0)
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_IDC, 16'h0000);
            wr(ADDR_IDC, 16'h0080 | 16'(s));
            wait_iv(t0);
            wait_iv(t1);
            `CHK(t1 - t0, 1 << (s > 5 ? 12 : 6 + s))
        end
        // slow divider rate first, then the fast rate, then the pin held low when disabled
        wr(ADDR_IDC, 16'h0040);
        ticks(4);
        rises = 0;
        ticks(256);
        `CHK(divider_out_oe, 1'b1)
        `CHK(rises inside {[3:5]}, 1'b1)
        wr(ADDR_IDC, 16'h0060);
        ticks(4);
        rises = 0;
        ticks(64);
        `CHK(rises inside {[31:33]}, 1'b1)
        wr(ADDR_IDC, 16'h0000);
        ticks(2);
        rises = 0;
        ticks(64);
        `CHK(divider_out_pin, 1'b0)
        `CHK(divider_out_oe, 1'b0)
        `CHK(rises, 0)
        wr(ADDR_RTCC0, 16'h0010);
        @(negedge clk);
        `CHK(clk32k_out_enable, 1'b1)
        results();
    end
endmodule
